/* File: src/sarsq_pkg.sv */
// constants and types shared by the sar converter sequencer
package sarsq_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h26;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h27;
  localparam logic [7:0] ADDR_RESULT_LOW_STATUS = 8'h28;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h29;

  // reset values
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h10;
  localparam logic [5:0] CONTROL_TWO_RESET = 6'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // control one fields
  localparam int START_BIT_POS = 7;
  localparam int MODE_MSB = 6;
  localparam int MODE_LSB = 5;
  localparam int GATING_BIT_POS = 4;
  localparam int CHANNEL_MSB = 3;
  localparam int CHANNEL_LSB = 0;

  // control two fields
  localparam int LADDER_BIT_POS = 5;
  localparam int CONV_TIME_MSB = 3;
  localparam int CONV_TIME_LSB = 1;

  // operating mode codes
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_RESERVED = 2'h2;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // conversion time codes and their lengths in high_frequency_clock periods
  localparam logic [2:0] CT_CODE_39 = 3'h0;
  localparam logic [2:0] CT_CODE_78 = 3'h2;
  localparam logic [2:0] CT_CODE_156 = 3'h3;
  localparam logic [2:0] CT_CODE_312 = 3'h4;
  localparam logic [2:0] CT_CODE_624 = 3'h5;
  localparam logic [2:0] CT_CODE_1248 = 3'h6;
  localparam logic [10:0] CT_LEN_39 = 11'h027;
  localparam logic [10:0] CT_LEN_78 = 11'h04E;
  localparam logic [10:0] CT_LEN_156 = 11'h09C;
  localparam logic [10:0] CT_LEN_312 = 11'h138;
  localparam logic [10:0] CT_LEN_624 = 11'h270;
  localparam logic [10:0] CT_LEN_1248 = 11'h4E0;

  // approximation timing: ten trials of three cycles each, ending one cycle before done
  localparam logic [10:0] BIT_PHASE_LEN = 11'h01F;
  localparam logic [3:0] TOP_BIT = 4'h9;

  // conversion lock-out after control one is cleared to zero
  localparam logic [2:0] HOLDOFF_CYCLES = 3'h4;

  typedef enum logic [1:0] {
    PH_SET,
    PH_SETTLE,
    PH_DECIDE
  } sarsq_phase_t;
endpackage

/* File: src/sarsq_top.sv */
// register file and successive approximation sequencer of the 10-bit converter
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module sarsq_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic stop_mode,
  input wire logic comparator_high,
  output logic [9:0] dac_code,
  output logic sample_hold,
  output logic [3:0] channel_select,
  output logic analog_input_enable,
  output logic ladder_connect,
  output logic conversion_done_interrupt,
  output logic converter_busy
);
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_one_d;
  logic [5:0] ctrl_two_q;
  logic [5:0] ctrl_two_d;
  logic [9:0] result_q;
  logic [9:0] sar_q;
  logic eoc_q;
  logic busy_q;
  logic done_q;
  logic [10:0] cnt_q;
  logic [10:0] len_q;
  logic [3:0] bit_idx_q;
  sarsq_pkg::sarsq_phase_t phase_q;
  logic [2:0] holdoff_q;
  logic cmp_meta_q;
  logic cmp_sync_q;
  logic [3:0] jitter_q;
  logic [7:0] rdata_q;
  logic sample_q;
  logic ladder_q;
  logic input_en_q;
  logic [3:0] chan_q;

  // decode
  wire wr_one = wr && (addr == sarsq_pkg::ADDR_CONTROL_ONE);
  wire wr_two = wr && (addr == sarsq_pkg::ADDR_CONTROL_TWO);
  wire rd_high = rd && (addr == sarsq_pkg::ADDR_RESULT_HIGH);
  wire [1:0] mode = ctrl_one_q[sarsq_pkg::MODE_MSB:sarsq_pkg::MODE_LSB];
  wire [1:0] wr_mode = wdata[sarsq_pkg::MODE_MSB:sarsq_pkg::MODE_LSB];
  wire [2:0] ct_code = ctrl_two_q[sarsq_pkg::CONV_TIME_MSB:sarsq_pkg::CONV_TIME_LSB];
  wire mode_runs = (mode == sarsq_pkg::MODE_SINGLE) || (mode == sarsq_pkg::MODE_REPEAT);
  wire abort = busy_q && (stop_mode || (wr_one && wr_mode == sarsq_pkg::MODE_DISABLED));
  wire last_cycle = busy_q && (cnt_q == len_q - 11'h001);
  wire complete = last_cycle && !abort;
  wire relaunch = complete && (mode == sarsq_pkg::MODE_REPEAT) && !wr_one;
  // start waits out the lock-out instead of being dropped
  wire sw_launch = ctrl_one_q[sarsq_pkg::START_BIT_POS] && mode_runs && !busy_q &&
                   (holdoff_q == 3'h0) && !stop_mode;
  wire launch = sw_launch || relaunch;
  wire [10:0] bit_start = len_q - sarsq_pkg::BIT_PHASE_LEN;
  wire in_bits = busy_q && (cnt_q >= bit_start) && !last_cycle;
  wire wr_zero = wr_one && (wdata == 8'h00);
  // the last trial's verdict only leaves the synchroniser in the completing cycle
  wire [9:0] final_code = {sar_q[9:1], sar_q[0] && !cmp_sync_q};

  // reserved codes run the longest period, the safe side for the reference
  function automatic logic [10:0] conv_len(input logic [2:0] code);
    case (code)
      sarsq_pkg::CT_CODE_39: conv_len = sarsq_pkg::CT_LEN_39;
      sarsq_pkg::CT_CODE_78: conv_len = sarsq_pkg::CT_LEN_78;
      sarsq_pkg::CT_CODE_156: conv_len = sarsq_pkg::CT_LEN_156;
      sarsq_pkg::CT_CODE_312: conv_len = sarsq_pkg::CT_LEN_312;
      sarsq_pkg::CT_CODE_624: conv_len = sarsq_pkg::CT_LEN_624;
      default: conv_len = sarsq_pkg::CT_LEN_1248;
    endcase
  endfunction

  // control one: stop holds reset, a write wins over the hardware clear of start
  always_comb begin
    ctrl_one_d = ctrl_one_q;
    if (stop_mode) begin
      ctrl_one_d = sarsq_pkg::CONTROL_ONE_RESET;
    end else if (wr_one) begin
      ctrl_one_d = wdata;
    end else if (sw_launch) begin
      ctrl_one_d[sarsq_pkg::START_BIT_POS] = 1'b0;
    end
  end

  // bits 0 and 4 are stored as written; software owns their values
  always_comb begin
    ctrl_two_d = ctrl_two_q;
    if (stop_mode) begin
      ctrl_two_d = sarsq_pkg::CONTROL_TWO_RESET;
    end else if (wr_two) begin
      ctrl_two_d = wdata[5:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_one_q <= sarsq_pkg::CONTROL_ONE_RESET;
      ctrl_two_q <= sarsq_pkg::CONTROL_TWO_RESET;
    end else begin
      ctrl_one_q <= ctrl_one_d;
      ctrl_two_q <= ctrl_two_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holdoff_q <= 3'h0;
    end else if (wr_zero) begin
      holdoff_q <= sarsq_pkg::HOLDOFF_CYCLES;
    end else if (holdoff_q != 3'h0) begin
      holdoff_q <= holdoff_q - 3'h1;
    end
  end

  // comparator is analog and asynchronous to clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= comparator_high;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 11'h000;
      len_q <= sarsq_pkg::CT_LEN_39;
    end else if (abort) begin
      busy_q <= 1'b0;
      cnt_q <= 11'h000;
    end else if (launch) begin
      busy_q <= 1'b1;
      cnt_q <= 11'h000;
      len_q <= conv_len(ct_code);
    end else if (complete) begin
      busy_q <= 1'b0;
      cnt_q <= 11'h000;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // three cycles per trial; a verdict clears the two-flop sync only at the next set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sar_q <= 10'h000;
      bit_idx_q <= sarsq_pkg::TOP_BIT;
      phase_q <= sarsq_pkg::PH_SET;
    end else if (launch) begin
      sar_q <= 10'h000;
      bit_idx_q <= sarsq_pkg::TOP_BIT;
      phase_q <= sarsq_pkg::PH_SET;
    end else if (in_bits) begin
      case (phase_q)
        sarsq_pkg::PH_SET: begin
          if ((bit_idx_q != sarsq_pkg::TOP_BIT) && cmp_sync_q) begin
            sar_q[bit_idx_q + 4'h1] <= 1'b0;
          end
          sar_q[bit_idx_q] <= 1'b1;
          phase_q <= sarsq_pkg::PH_SETTLE;
        end
        sarsq_pkg::PH_SETTLE: begin
          phase_q <= sarsq_pkg::PH_DECIDE;
        end
        sarsq_pkg::PH_DECIDE: begin
          bit_idx_q <= bit_idx_q - 4'h1;
          phase_q <= sarsq_pkg::PH_SET;
        end
        default: begin
          phase_q <= sarsq_pkg::PH_SET;
        end
      endcase
    end
  end

  // result and end flag: completion wins over the clearing read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_q <= sarsq_pkg::RESULT_RESET;
      eoc_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= complete;
      if (stop_mode) begin
        result_q <= sarsq_pkg::RESULT_RESET;
        eoc_q <= 1'b0;
      end else if (complete) begin
        result_q <= final_code;
        eoc_q <= 1'b1;
      end else if (rd_high || sw_launch) begin
        eoc_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      jitter_q <= 4'h0;
    end else begin
      jitter_q <= jitter_q + 4'h1;
    end
  end

  // read data live only in the cycle after the strobe
  wire [7:0] rd_mux =
    (addr == sarsq_pkg::ADDR_CONTROL_ONE) ? ctrl_one_q :
    (addr == sarsq_pkg::ADDR_CONTROL_TWO) ? {2'h0, ctrl_two_q} :
    (addr == sarsq_pkg::ADDR_RESULT_LOW_STATUS) ?
      {result_q[1:0], eoc_q, busy_q, jitter_q} :
    (addr == sarsq_pkg::ADDR_RESULT_HIGH) ? result_q[9:2] : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_q <= 1'b0;
      ladder_q <= 1'b0;
      input_en_q <= 1'b0;
      chan_q <= 4'h0;
    end else begin
      sample_q <= busy_q && (cnt_q < bit_start);
      ladder_q <= ctrl_two_q[sarsq_pkg::LADDER_BIT_POS] || busy_q;
      input_en_q <= !ctrl_one_q[sarsq_pkg::GATING_BIT_POS];
      chan_q <= ctrl_one_q[sarsq_pkg::CHANNEL_MSB:sarsq_pkg::CHANNEL_LSB];
    end
  end

  assign rdata = rdata_q;
  assign dac_code = sar_q;
  assign sample_hold = sample_q;
  assign channel_select = chan_q;
  assign analog_input_enable = input_en_q;
  assign ladder_connect = ladder_q;
  assign conversion_done_interrupt = done_q;
  assign converter_busy = busy_q;

  // checking helpers
  logic [10:0] run_cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n || launch) begin
      run_cnt_q <= 11'h000;
    end else if (busy_q) begin
      run_cnt_q <= run_cnt_q + 11'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_start_self_clear: assert property (sw_launch && !wr_one |=>
    busy_q && !ctrl_one_q[sarsq_pkg::START_BIT_POS])
    else $error("start bit not cleared at launch");
  a_done_sets_flag: assert property (complete |=> eoc_q && done_q &&
    result_q == $past(final_code))
    else $error("completion did not store and flag");
  a_period_length: assert property (complete |-> run_cnt_q == len_q - 11'h001)
    else $error("conversion length wrong");
  a_len_select: assert property (launch && ct_code == sarsq_pkg::CT_CODE_312 |=>
    len_q == sarsq_pkg::CT_LEN_312)
    else $error("conversion time decode wrong");
  a_single_ends: assert property (complete && mode == sarsq_pkg::MODE_SINGLE |=>
    !busy_q)
    else $error("busy stayed set after single");
  a_repeat_again: assert property (relaunch |=> busy_q && cnt_q == 11'h000)
    else $error("repeat did not relaunch");
  a_abort_no_store: assert property (abort |=> !busy_q && !done_q &&
    $stable(result_q) || $past(stop_mode))
    else $error("abort stored a result");
  a_high_read_clear: assert property (rd_high && !complete |=> !eoc_q)
    else $error("end flag kept after high read");
  a_stop_holds: assert property (stop_mode |=>
    ctrl_one_q == sarsq_pkg::CONTROL_ONE_RESET && !busy_q)
    else $error("stop did not hold controls");
  a_zero_lockout: assert property (wr_zero |=> !sw_launch [*4])
    else $error("launch inside lock-out");
  a_ladder_busy: assert property (busy_q |=> ladder_q)
    else $error("ladder off while converting");
  a_upper_ro: assert property (rd && addr == sarsq_pkg::ADDR_CONTROL_TWO |=>
    rdata_q[7:6] == 2'h0)
    else $error("control two upper bits");
  // trial, flag, mode, output and read-back checks
  a_launch_busy: assert property (launch |=>
    busy_q)
    else $error("launch did not set busy");
  a_done_pulse: assert property (done_q |=>
    !done_q)
    else $error("done pulse longer than one cycle");
  a_done_at_end: assert property (done_q |->
    $past(last_cycle))
    else $error("done pulse without a finished period");
  a_reserved_idle: assert property (!busy_q && mode == sarsq_pkg::MODE_RESERVED |=>
    !busy_q)
    else $error("reserved mode started a conversion");
  a_disabled_idle: assert property (!busy_q && mode == sarsq_pkg::MODE_DISABLED |=>
    !busy_q)
    else $error("disabled mode started a conversion");
  a_gate_follows: assert property (
    input_en_q == !$past(ctrl_one_q[sarsq_pkg::GATING_BIT_POS]))
    else $error("input enable does not follow gating bit");
  a_chan_follows: assert property (
    chan_q == $past(ctrl_one_q[sarsq_pkg::CHANNEL_MSB:sarsq_pkg::CHANNEL_LSB]))
    else $error("channel output does not follow field");
  a_restart_clears: assert property (sw_launch |=>
    !eoc_q)
    else $error("software start kept end flag");
  a_restart_keeps: assert property (sw_launch |=>
    $stable(result_q))
    else $error("software start disturbed old result");
  a_stop_clears: assert property (stop_mode |=> !eoc_q &&
    ctrl_two_q == sarsq_pkg::CONTROL_TWO_RESET && result_q == sarsq_pkg::RESULT_RESET)
    else $error("stop did not clear result and flag");
  a_low_fields: assert property (rd && addr == sarsq_pkg::ADDR_RESULT_LOW_STATUS |=>
    rdata_q[7:4] == {$past(result_q[1:0]), $past(eoc_q), $past(busy_q)})
    else $error("low status fields misplaced");
  a_high_fields: assert property (rd_high |=>
    rdata_q == $past(result_q[9:2]))
    else $error("high result bits misplaced");
  a_sar_restart: assert property (launch |=>
    sar_q == 10'h000 && bit_idx_q == sarsq_pkg::TOP_BIT)
    else $error("trial register not cleared at launch");
  a_ladder_idle: assert property (!busy_q && !ctrl_two_q[sarsq_pkg::LADDER_BIT_POS] |=>
    !ladder_q)
    else $error("ladder on while idle");
  a_ladder_always: assert property (ctrl_two_q[sarsq_pkg::LADDER_BIT_POS] |=>
    ladder_q)
    else $error("ladder off while held on");
  a_sample_busy: assert property (sample_q |->
    $past(busy_q))
    else $error("sample phase outside a conversion");
  a_eoc_holds: assert property (eoc_q && !rd_high && !sw_launch && !stop_mode |=>
    eoc_q)
    else $error("end flag dropped without a clear");
endmodule

/* File: testbench/sarsq_cmp_model.sv */
// behavioural analog comparator and input levels facing the converter
`timescale 1ns/1ps
module sarsq_cmp_model (
  input wire logic [9:0] dac_code,
  input wire logic [3:0] channel_select,
  input wire logic analog_input_enable,
  input wire logic [15:0][9:0] vin,
  output logic comparator_high
);
  // a gated input reads as ground, so every trial is rejected
  assign comparator_high = !analog_input_enable || (dac_code > vin[channel_select]);
endmodule

/* File: testbench/sarsq_top_tb.sv */
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module sarsq_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop_mode = 1'b0;
  logic [7:0] rdata;
  logic comparator_high;
  logic [9:0] dac_code;
  logic sample_hold;
  logic [3:0] channel_select;
  logic analog_input_enable;
  logic ladder_connect;
  logic conversion_done_interrupt;
  logic converter_busy;
  logic [15:0][9:0] vin;
  int fails = 0;
  int cmp_count = 0;

  sarsq_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .stop_mode(stop_mode), .comparator_high(comparator_high),
    .dac_code(dac_code), .sample_hold(sample_hold), .channel_select(channel_select),
    .analog_input_enable(analog_input_enable), .ladder_connect(ladder_connect),
    .conversion_done_interrupt(conversion_done_interrupt), .converter_busy(converter_busy));
  sarsq_cmp_model u_cmp (.dac_code(dac_code), .channel_select(channel_select),
    .analog_input_enable(analog_input_enable), .vin(vin), .comparator_high(comparator_high));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  // counts busy cycles until the done pulse; a missing pulse ends the run
  task automatic wdone(output int k);
    int i;
    k = 0;
    for (i = 0; i < 1500 && conversion_done_interrupt !== 1'b1; i++) begin
      @(posedge clk);
      if (converter_busy === 1'b1) k++;
      if (k == 5) chk("ladder_busy", 16'h1, 16'(ladder_connect));
      if (k == 5) chk("sample_hold", 16'h1, 16'(sample_hold));
    end
    if (conversion_done_interrupt !== 1'b1) begin
      chk("done_pulse", 16'h1, 16'h0);
      wrap_up();
    end
  endtask

  task automatic t_reset();
    logic [7:0] v;
    chk("input_enable", 16'h0, 16'(analog_input_enable));
    rreg(8'h26, v);
    chk("control_one", 16'h10, 16'(v));
    rreg(8'h27, v);
    chk("control_two", 16'h00, 16'(v));
    rreg(8'h30, v);
    chk("unmapped", 16'h00, 16'(v));
  endtask

  task automatic t_conv(input logic [2:0] code, input int n, input logic [3:0] ch);
    int k;
    logic [7:0] v;
    wreg(8'h27, {4'h1, code, 1'b0});
    wreg(8'h26, {3'h1, 1'b0, ch});
    repeat (2) @(posedge clk);
    chk("input_enable", 16'h1, 16'(analog_input_enable));
    chk("channel", {12'h000, ch}, {12'h000, channel_select});
    wreg(8'h26, {3'h5, 1'b0, ch});
    wdone(k);
    chk("busy_len", 16'(n), 16'(k));
    rreg(8'h28, v);
    chk("low_status", {12'h000, vin[ch][1:0], 2'h2}, {12'h000, v[7:4]});
    rreg(8'h29, v);
    chk("result_high", {8'h00, vin[ch][9:2]}, 16'(v));
    rreg(8'h28, v);
    chk("eoc_cleared", 16'h0, 16'(v[5]));
    rreg(8'h26, v);
    chk("start_clear", {8'h00, 3'h1, 1'b0, ch}, 16'(v));
    chk("ladder_idle", 16'h0, 16'(ladder_connect));
  endtask

  task automatic t_repeat();
    int k;
    logic [7:0] v;
    wreg(8'h27, 8'h10);
    wreg(8'h26, 8'hE3);
    wdone(k);
    @(posedge clk);
    wdone(k);
    @(posedge clk);
    chk("repeat_busy", 16'h1, 16'(converter_busy));
    vin[3] <= 10'h2AA;
    repeat (8) @(posedge clk);
    wreg(8'h26, 8'h03);
    @(posedge clk);
    @(posedge clk);
    chk("abort_busy", 16'h0, 16'(converter_busy));
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (conversion_done_interrupt !== 1'b0) chk("abort_done", 16'h0, 16'h1);
    end
    rreg(8'h29, v);
    chk("abort_keep", {8'h00, 8'h30}, 16'(v));
  endtask

  task automatic t_lock_stop();
    logic [7:0] v;
    wreg(8'h26, 8'h00);
    wreg(8'h26, 8'hA5);
    @(posedge clk);
    @(posedge clk);
    chk("lockout", 16'h0, 16'(converter_busy));
    wreg(8'h27, 8'h3C);
    repeat (20) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk("stop_busy", 16'h0, 16'(converter_busy));
    wreg(8'h26, 8'h45);
    rreg(8'h26, v);
    chk("stop_ctl_one", 16'h10, 16'(v));
    rreg(8'h27, v);
    chk("stop_ctl_two", 16'h00, 16'(v));
    rreg(8'h29, v);
    chk("stop_result", 16'h00, 16'(v));
    @(posedge clk);
    stop_mode <= 1'b0;
    wreg(8'h27, 8'h30);
    repeat (3) @(posedge clk);
    chk("ladder_always", 16'h1, 16'(ladder_connect));
  endtask

  initial begin
    for (int i = 0; i < 16; i++) vin[i] = 10'(i) * 10'h043 + 10'h005;
    vin[3] = 10'h0C2;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_conv(3'h0, 39, 4'h0);
    t_conv(3'h2, 78, 4'hF);
    t_conv(3'h3, 156, 4'h7);
    t_conv(3'h4, 312, 4'h9);
    t_conv(3'h5, 624, 4'h2);
    t_conv(3'h6, 1248, 4'hC);
    t_conv(3'h1, 1248, 4'h5);
    t_repeat();
    t_lock_stop();
    wrap_up();
  end
endmodule
